// ---- core/dsm_device.sv ----
// Top: device-control state machine of a motor drive
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Command word used only under selector 1
// - Motion config: enable needs safe release
// - Other configs: release plus a start input
// - Command bits 9 to 15 ignored, except as motion high byte
// - Mode bits and halt only in motion
// - Bit 4 shows mains; switch-on needs mains
// - Bits 0-3 encode shutdown, switch on, enable
// - Disable voltage, quick stop, fault reset edge
// - State word bits encode seven states
// - Motion config: no 4', start inputs ignored
// - Mode object selects motion operating mode
// - Non-motion: 4' allowed only with mains
// - Bit 7 follows any internal warning
// - Bit 9: selector 1 and hardware release
// - Bit 10: target reached within band
// - Non-motion: target velocity ref, 0 Hz case
// - Bit 11 follows internal limiter activity
// - Bit 15 follows pre-fault warnings
// - Non-motion: mode fixed at 2
module dsm_device
  import dsm_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Command word and modes object write ports
  input  wire logic             cmdWrite,        // Write strobe for command word
  input  wire logic [15:0]      cmdData,         // Written command word
  input  wire logic             modeWrite,       // Write strobe for modes object
  input  wire logic [7:0]       modeData,        // Written mode value
  // Configuration
  input  wire logic [5:0]       ctrlSource,      // Control source selector
  input  wire logic [7:0]       configLow,       // Low part of configuration number
  // Hardware release inputs
  input  wire logic             torque_off_a,
  input  wire logic             torque_off_b,
  input  wire logic             start_cw_input,
  input  wire logic             start_ccw_input,
  // Drive status sources
  input  wire logic             mainsOn,         // Mains voltage present
  input  wire logic             driveFault,      // Fault detected
  input  wire logic             faultReactDone,  // Fault reaction finished
  input  wire logic             stopDone,        // Quick stop ramp finished
  input  wire logic             warnAny,         // Any internal warning
  input  wire logic             warnPreFault,    // Pre-fault warning
  input  wire logic             limitActive,     // Internal limiter active
  input  wire logic [1:0]       modeStatus,      // Mode-specific status bits
  input  wire logic [VAL_W-1:0] actualValue,     // Actual value
  input  wire logic [VAL_W-1:0] targetVelocity,  // Target velocity object
  input  wire logic [VAL_W-1:0] motionReference, // Motion reference value
  input  wire logic [VAL_W-1:0] tolerance,       // Control deviation band
  input  wire logic             pwrFailZero,     // Power-fail regulation at 0 Hz
  // Outputs
  output logic [15:0]           stateWord,       // State word
  output logic [15:0]           cmdWordRead,     // Command word read back
  output logic [7:0]            modeDisplay,     // Modes of operation display
  output logic [2:0]            motionBits,      // Mode-specific command bits
  output logic                  haltOut,         // Halt to motion profile
  output logic [7:0]            motionHighByte,  // High byte for motion start
  output logic                  powerStageOn     // Power stage enabled
);

  // ************************************************************
  // Declarations
  // ************************************************************
  dsm_state_e  state_r, state_nxt;         // Device state
  logic [15:0] cmd_r, cmd_nxt;             // Stored command word
  logic        frPrev_r, frPrev_nxt;       // Previous fault reset bit
  logic [7:0]  mode_r, mode_nxt;           // Operating mode
  logic [15:0] sw_r, sw_nxt;               // State word register
  logic [2:0]  mbits_r, mbits_nxt;         // Mode-specific command out
  logic        halt_r, halt_nxt;           // Halt out
  logic [7:0]  hiByte_r, hiByte_nxt;       // High byte out
  logic        pwr_r, pwr_nxt;             // Power stage out
  logic        isMotion;                   // Motion-control configuration
  logic        smCtrl;                     // State-machine control selected
  logic        safeRelease;                // Safe release input
  logic        enableOk;                   // Hardware release present
  logic        faultResetEdge;             // Rising edge of fault reset
  logic        targetHit;                  // Comparator result
  logic [VAL_W-1:0] refSel;                // Selected reference

  assign isMotion    = (configLow == CFG_MOTION_LOW);
  assign smCtrl      = (ctrlSource == CTRL_SRC_STATE_MACHINE);
  assign safeRelease = torque_off_a & torque_off_b;
  // Start inputs matter only outside motion config; tying them on
  // reduces release to the safe input alone
  always_comb begin
    if (isMotion) begin
      enableOk = safeRelease;
    end else begin
      // Mains gating belongs to 4' and 3 only, not to transition 4
      enableOk = safeRelease & (start_cw_input | start_ccw_input);
    end
  end
  assign faultResetEdge = cmd_r[CW_FAULT_RESET] & ~frPrev_r;

  // ************************************************************
  // Target-reached comparator
  // ************************************************************
  assign refSel = isMotion ? motionReference : targetVelocity;
  dsm_target_cmp u_target (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .refValue    (refSel),
    .actValue    (actualValue),
    .tolerance   (tolerance),
    .pwrFailZero (pwrFailZero & ~isMotion),
    .reached     (targetHit)
  );

  // ************************************************************
  // Command and mode object storage
  // ************************************************************
  // Command writes always store, mode writes only in motion config; whether they steer the drive is decided by
  // the selector, so a switch of source takes effect at once
  always_comb begin
    cmd_nxt    = cmd_r;
    mode_nxt   = mode_r;
    frPrev_nxt = cmd_r[CW_FAULT_RESET];
    if (cmdWrite) begin
      cmd_nxt = cmdData;
    end
    if (!isMotion) begin
      mode_nxt = MODE_VELOCITY;
    end else if (modeWrite) begin
      mode_nxt = modeData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_r    <= CMD_WORD_RESET;
      mode_r   <= MODE_VELOCITY;
      frPrev_r <= 1'b0;
    end else begin
      cmd_r    <= cmd_nxt;
      mode_r   <= mode_nxt;
      frPrev_r <= frPrev_nxt;
    end
  end

  // ************************************************************
  // Device state machine
  // ************************************************************
  // Only bits 0-3 and 7 are decoded; bits 9-15 never reach here
  always_comb begin
    logic sOn, eV, qS, eO;
    sOn = cmd_r[CW_SWITCH_ON];
    eV  = cmd_r[CW_ENABLE_VOLT];
    qS  = cmd_r[CW_QUICK_STOP];
    eO  = cmd_r[CW_ENABLE_OP];
    state_nxt = state_r;
    if (driveFault && state_r != ST_FAULT && state_r != ST_FAULT_REACT) begin
      state_nxt = ST_FAULT_REACT;
    end else begin
      case (state_r)
        ST_FAULT_REACT: begin
          if (faultReactDone) state_nxt = ST_FAULT;
        end
        ST_FAULT: begin
          if (smCtrl && faultResetEdge) state_nxt = ST_SO_DISABLED;
        end
        ST_SO_DISABLED: begin
          if (smCtrl && eV && qS && !sOn) state_nxt = ST_READY;   // 2
        end
        ST_READY: begin
          if (!smCtrl) state_nxt = ST_READY;
          else if (!eV || !qS) state_nxt = ST_SO_DISABLED;        // 7
          // 4' is tested first, else the switch-on branch would shadow it
          else if (!isMotion && sOn && eO && enableOk && mainsOn)
            state_nxt = ST_OP_ENABLED;                            // 4'
          else if (sOn && mainsOn) state_nxt = ST_SWITCHED_ON;    // 3
        end
        ST_SWITCHED_ON: begin
          if (!smCtrl) state_nxt = ST_SWITCHED_ON;
          else if (!eV || !qS) state_nxt = ST_SO_DISABLED;        // 10
          else if (!sOn) state_nxt = ST_READY;                    // 6
          else if (eO && enableOk) state_nxt = ST_OP_ENABLED;     // 4
        end
        ST_OP_ENABLED: begin
          if (!smCtrl) state_nxt = ST_OP_ENABLED;
          else if (!eV) state_nxt = ST_SO_DISABLED;               // 9
          else if (!qS) state_nxt = ST_QUICK_STOP;                // 11
          else if (!sOn) state_nxt = ST_READY;                    // 8
          else if (!eO) state_nxt = ST_SWITCHED_ON;               // 5
        end
        ST_QUICK_STOP: begin
          if (stopDone || (smCtrl && !eV)) state_nxt = ST_SO_DISABLED; // 12
        end
        default: state_nxt = ST_SO_DISABLED;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_SO_DISABLED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // State word and outputs
  // ************************************************************
  always_comb begin
    sw_nxt = 16'h0000;
    case (state_nxt)
      ST_SO_DISABLED: sw_nxt[SW_SO_DISABLED] = 1'b1;
      ST_READY:       sw_nxt[SW_QS_N] = 1'b1;
      ST_SWITCHED_ON: sw_nxt[SW_QS_N] = 1'b1;
      ST_OP_ENABLED:  sw_nxt[SW_QS_N] = 1'b1;
      ST_FAULT_REACT: sw_nxt[SW_FAULT] = 1'b1;
      ST_FAULT:       sw_nxt[SW_FAULT] = 1'b1;
      default:        sw_nxt[SW_QS_N] = 1'b0;
    endcase
    if (state_nxt inside {ST_READY, ST_SWITCHED_ON, ST_OP_ENABLED,
                          ST_QUICK_STOP, ST_FAULT_REACT}) begin
      sw_nxt[SW_READY] = 1'b1;
    end
    if (state_nxt inside {ST_SWITCHED_ON, ST_OP_ENABLED,
                          ST_QUICK_STOP, ST_FAULT_REACT}) begin
      sw_nxt[SW_SWITCHED_ON] = 1'b1;
    end
    if (state_nxt inside {ST_OP_ENABLED, ST_QUICK_STOP, ST_FAULT_REACT}) begin
      sw_nxt[SW_OP_ENABLED] = 1'b1;
    end
    sw_nxt[SW_MAINS]    = mainsOn;
    sw_nxt[SW_WARNING]  = warnAny;
    // Release outside motion config includes a start input
    sw_nxt[SW_REMOTE]   = smCtrl & enableOk;
    sw_nxt[SW_TARGET]   = targetHit;
    sw_nxt[SW_LIMIT]    = limitActive;
    sw_nxt[SW_WARNING2] = warnPreFault;
    if (isMotion) begin
      sw_nxt[SW_MODE_HI:SW_MODE_LO] = modeStatus;
    end
    // Motion-only command fields pass on solely in motion config,
    // and the high byte waits for operation enabled
    mbits_nxt  = (isMotion && smCtrl) ? cmd_r[CW_MODE_HI:CW_MODE_LO] : 3'h0;
    halt_nxt   = isMotion & smCtrl & cmd_r[CW_HALT];
    hiByte_nxt = (isMotion && smCtrl && state_nxt == ST_OP_ENABLED)
               ? cmd_r[15:8] : 8'h00;
    pwr_nxt    = (state_nxt == ST_OP_ENABLED) || (state_nxt == ST_QUICK_STOP);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sw_r     <= 16'h0040;
      mbits_r  <= 3'h0;
      halt_r   <= 1'b0;
      hiByte_r <= 8'h00;
      pwr_r    <= 1'b0;
    end else begin
      sw_r     <= sw_nxt;
      mbits_r  <= mbits_nxt;
      halt_r   <= halt_nxt;
      hiByte_r <= hiByte_nxt;
      pwr_r    <= pwr_nxt;
    end
  end

  assign stateWord      = sw_r;
  assign cmdWordRead    = cmd_r;
  assign modeDisplay    = mode_r;
  assign motionBits     = mbits_r;
  assign haltOut        = halt_r;
  assign motionHighByte = hiByte_r;
  assign powerStageOn   = pwr_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_switchOnCmd;
    smCtrl && state_r == ST_READY && cmd_r[2:0] == 3'h7;
  endsequence

  a_selector_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (!smCtrl && !driveFault && state_r inside {ST_READY, ST_SWITCHED_ON})
    |=> $stable(state_r))
    else $error("State moved without state-machine control");
  a_motion_enable: assert property (@(posedge ref_clk) disable iff (rst)
    (isMotion && !safeRelease && state_r != ST_OP_ENABLED) |=> state_r != ST_OP_ENABLED)
    else $error("Enable without safe release");
  a_start_needed: assert property (@(posedge ref_clk) disable iff (rst)
    (!isMotion && !start_cw_input && !start_ccw_input && state_r == ST_SWITCHED_ON)
    |=> state_r != ST_OP_ENABLED)
    else $error("Enable without start input");
  a_mains_switch: assert property (@(posedge ref_clk) disable iff (rst)
    (s_switchOnCmd ##0 !mainsOn && !driveFault) |=> state_r == ST_READY)
    else $error("Switch on without mains");
  a_mains_bit: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> stateWord[SW_MAINS] == $past(mainsOn))
    else $error("Mains bit wrong");
  a_halt_motion: assert property (@(posedge ref_clk) disable iff (rst)
    !isMotion |=> !haltOut && stateWord[SW_MODE_HI:SW_MODE_LO] == 2'h0)
    else $error("Motion field outside motion config");
  a_state_pattern: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == ST_OP_ENABLED |-> stateWord[6] == 1'b0 && stateWord[3:0] == 4'h7)
    else $error("Operation enabled pattern wrong");
  a_remote_bit: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> stateWord[SW_REMOTE] == $past(smCtrl && enableOk))
    else $error("Remote bit wrong");
  a_mode_fixed: assert property (@(posedge ref_clk) disable iff (rst)
    !isMotion |=> modeDisplay == MODE_VELOCITY)
    else $error("Mode not fixed at velocity");
  a_fault_reset: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_FAULT && smCtrl && faultResetEdge && !driveFault)
    |=> state_r == ST_SO_DISABLED && stateWord[SW_SO_DISABLED])
    else $error("Fault reset not taken");

endmodule : dsm_device
`default_nettype wire

// ---- core/dsm_pkg.sv ----
// Package: constants and types of the drive device state machine
package dsm_pkg;

  // ************************************************************
  // Object indices and identifiers
  // ************************************************************
  localparam logic [15:0] CMD_WORD_INDEX   = 16'h6040; // Command word object
  localparam logic [15:0] MODES_OBJ_INDEX  = 16'h6060; // Modes of operation object
  localparam logic [15:0] TARGET_VEL_INDEX = 16'h6042; // Target velocity object

  // ************************************************************
  // Control source selector and configuration values
  // ************************************************************
  localparam logic [5:0] CTRL_SRC_STATE_MACHINE = 6'h01; // Selector value 1
  localparam logic [7:0] CFG_MOTION_LOW         = 8'h40; // Config ending x40
  localparam logic [7:0] MODE_VELOCITY          = 8'h02; // Velocity mode, fixed value 2

  // ************************************************************
  // Command word bit positions
  // ************************************************************
  localparam int CW_SWITCH_ON   = 0;
  localparam int CW_ENABLE_VOLT = 1;
  localparam int CW_QUICK_STOP  = 2;
  localparam int CW_ENABLE_OP   = 3;
  localparam int CW_MODE_LO     = 4; // Mode-specific bits 4..6
  localparam int CW_MODE_HI     = 6;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT        = 8;

  // ************************************************************
  // State word bit positions
  // ************************************************************
  localparam int SW_READY       = 0;
  localparam int SW_SWITCHED_ON = 1;
  localparam int SW_OP_ENABLED  = 2;
  localparam int SW_FAULT       = 3;
  localparam int SW_MAINS       = 4;
  localparam int SW_QS_N        = 5;
  localparam int SW_SO_DISABLED = 6;
  localparam int SW_WARNING     = 7;
  localparam int SW_REMOTE      = 9;
  localparam int SW_TARGET      = 10;
  localparam int SW_LIMIT       = 11;
  localparam int SW_MODE_LO     = 12; // Mode-specific bits 12..13
  localparam int SW_MODE_HI     = 13;
  localparam int SW_WARNING2    = 15;

  // ************************************************************
  // Reset values and widths
  // ************************************************************
  localparam logic [15:0] CMD_WORD_RESET = 16'h0000; // Command word after reset
  localparam int          VAL_W          = 16;       // Reference/actual width

  // State machine states
  typedef enum logic [2:0] {
    ST_SO_DISABLED,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_QUICK_STOP,
    ST_FAULT_REACT,
    ST_FAULT
  } dsm_state_e;

endpackage : dsm_pkg

// ---- core/dsm_target_cmp.sv ----
// Target-reached comparator with tolerance band hysteresis
`timescale 1ns/1ps
`default_nettype none
module dsm_target_cmp
  import dsm_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [VAL_W-1:0] refValue,    // Commanded reference (signed)
  input  wire logic [VAL_W-1:0] actValue,    // Actual value (signed)
  input  wire logic [VAL_W-1:0] tolerance,   // Band width, unsigned
  input  wire logic             pwrFailZero, // Power-failure regulation at 0 Hz
  output logic                  reached      // Target reached flag
);

  logic             reached_r;   // Held flag
  logic             reached_nxt; // Next flag
  logic [VAL_W:0]   diffAbs;     // Magnitude of deviation

  // ************************************************************
  // Deviation and hysteresis
  // ************************************************************
  // Set inside band, clear only outside twice the band, so the
  // flag does not chatter at the band edge
  always_comb begin
    logic signed [VAL_W:0] d;
    d = '0;
    d = $signed({refValue[VAL_W-1], refValue}) - $signed({actValue[VAL_W-1], actValue});
    diffAbs = d[VAL_W] ? (VAL_W+1)'(0) - d : d;
    reached_nxt = reached_r;
    if (pwrFailZero) begin
      reached_nxt = 1'b1;
    end else if (diffAbs <= {1'b0, tolerance}) begin
      reached_nxt = 1'b1;
    end else if (diffAbs > {tolerance, 1'b0}) begin
      reached_nxt = 1'b0;
    end
  end

  // Register only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reached_r <= 1'b0;
    end else begin
      reached_r <= reached_nxt;
    end
  end

  assign reached = reached_r;

endmodule : dsm_target_cmp
`default_nettype wire

// ---- tb/dsm_plc_model.sv ----
// Fieldbus master model that writes the command and mode objects
`timescale 1ns/1ps
`default_nettype none
module dsm_plc_model (
  input  wire logic        ref_clk,
  output logic             cmdWrite,
  output logic [15:0]      cmdData,
  output logic             modeWrite,
  output logic [7:0]       modeData
);
  // ************************************************************
  // Write cycles
  // ************************************************************
  // Idle after power-up, no strobe
  initial begin
    cmdWrite  = 1'b0;
    cmdData   = 16'h0000;
    modeWrite = 1'b0;
    modeData  = 8'h00;
  end
  // One-cycle strobe; released data is inverted so nothing stale looks valid
  task automatic sendCmd(input logic [15:0] c);
    @(posedge ref_clk);
    #1 cmdWrite = 1'b1;
    cmdData = c;
    @(posedge ref_clk);
    #1 cmdWrite = 1'b0;
    cmdData = ~c;
  endtask : sendCmd
  // Mode object write, same timing as a command
  task automatic sendMode(input logic [7:0] m);
    @(posedge ref_clk);
    #1 modeWrite = 1'b1;
    modeData = m;
    @(posedge ref_clk);
    #1 modeWrite = 1'b0;
    modeData = ~m;
  endtask : sendMode
endmodule : dsm_plc_model
`default_nettype wire

// ---- tb/test_drive_device_state_machine.sv ----
// Self-checking bench of the drive device state machine
`timescale 1ns/1ps
`default_nettype none
module test_drive_device_state_machine;
  import dsm_pkg::*;
  // ************************************************************
  // Signals and reference model state
  // ************************************************************
  logic        ref_clk, rst, cmdWrite, modeWrite, haltOut, staA, staB;
  logic        cw, ccw, mains, flt, frd, sdone, warn, pre, lim;
  logic [15:0] cmdData, stateWord, prev;
  logic [31:0] seed, r;
  logic [7:0]  modeData, cfg, modeDisplay;
  logic [5:0]  src;
  logic [2:0]  motionBits;
  logic [1:0]  mstat;
  logic        pfz, hit, pwr;      // Power-fail input, expected target bit, power stage
  logic [15:0] act, cwr;           // Actual value, command read back
  logic [7:0]  hib;                // Motion high byte
  int          st, n_errors, tests_run; // Model state: 0 off .. 6 fault
  dsm_plc_model plc (.ref_clk(ref_clk), .cmdWrite(cmdWrite), .cmdData(cmdData),
    .modeWrite(modeWrite), .modeData(modeData));
  dsm_device dut (.ref_clk(ref_clk), .rst(rst), .cmdWrite(cmdWrite), .cmdData(cmdData),
    .modeWrite(modeWrite), .modeData(modeData), .ctrlSource(src), .configLow(cfg),
    .torque_off_a(staA), .torque_off_b(staB), .start_cw_input(cw),
    .start_ccw_input(ccw), .mainsOn(mains), .driveFault(flt), .faultReactDone(frd),
    .stopDone(sdone), .warnAny(warn), .warnPreFault(pre), .limitActive(lim),
    .modeStatus(mstat), .actualValue(act), .targetVelocity(16'h0100),
    .motionReference(16'h0300), .tolerance(16'h0004), .pwrFailZero(pfz),
    .stateWord(stateWord), .cmdWordRead(cwr), .modeDisplay(modeDisplay),
    .motionBits(motionBits), .haltOut(haltOut), .motionHighByte(hib), .powerStageOn(pwr));
  // Free-running clock, 8 ns
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // Compare state word and motion outputs with the model
  task automatic look();
    logic [15:0] w, m;
    logic        mo;
    mo = (cfg == CFG_MOTION_LOW);
    case (st)
      0: w = 16'h0040;
      1: w = 16'h0021;
      2: w = 16'h0023;
      3: w = 16'h0027;
      4: w = 16'h0007;
      5: w = 16'h000F;
      default: w = 16'h0008;
    endcase
    w[4] = mains;
    w[7] = warn;
    w[9] = (src == CTRL_SRC_STATE_MACHINE) && staA && staB && (mo || cw || ccw);
    w[10] = hit; // Set by each target scenario
    w[11] = lim;
    w[15] = pre;
    w[13:12] = mo ? mstat : 2'b00;
    m = (st == 0 || st > 4) ? 16'hBEDF : 16'hBEFF; // Quick-stop bit free where X
    check("stateWord", stateWord & m, w & m);
    check("motion", {12'h000, motionBits, haltOut},
          mo ? {12'h000, prev[6:4], prev[8]} : 16'h0000);
    check("cmdWordRead", cwr, prev);
    check("highByte", {8'h00, hib}, (mo && st == 3 && src == CTRL_SRC_STATE_MACHINE)
          ? {8'h00, prev[15:8]} : 16'h0000);
    check("powerStage", {15'h0000, pwr}, {15'h0000, st inside {3, 4}});
  endtask : look
  // Send one command with random don't-care bits, step the model
  task automatic command(input logic [15:0] c);
    logic mo, rel;
    r = rnd();
    mo = (cfg == CFG_MOTION_LOW);
    rel = staA && staB && (mo || cw || ccw);
    if (src == CTRL_SRC_STATE_MACHINE) begin
      if (st == 6 && c[7] && !prev[7]) st = 0;
      // Stored word keeps acting, so a second step may follow
      repeat (2) begin
        if (!c[1] && st inside {1, 2, 3, 4}) st = 0;
        else if (c[2:1] == 2'b01 && st inside {1, 2}) st = 0;
        else if (c[2:1] == 2'b01 && st == 3) st = 4;
        else if (c[2:0] == 3'b110 && st inside {0, 2, 3}) st = 1;
        else if (c[3:0] == 4'hF && rel && (st == 2 || (st == 1 && !mo && mains))) st = 3;
        else if (c[2:0] == 3'b111 && st == 1 && mains) st = 2;
        else if (c[3:0] == 4'h7 && st == 3) st = 2;
      end
    end
    prev = c | (r[15:0] & 16'hFF70);
    plc.sendCmd(prev);
    repeat (3) @(posedge ref_clk);
    #1 look();
  endtask : command
  // Let level inputs act, then compare
  task automatic settle();
    if (flt && st < 5) st = 5;
    else if (st == 5 && frd) st = 6;
    if (st == 4 && sdone) st = 0;
    repeat (4) @(posedge ref_clk);
    #1 look();
  endtask : settle
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {rst, staA, staB, mains, src} = {4'hF, CTRL_SRC_STATE_MACHINE};
    {cw, ccw, flt, frd, sdone, warn, pre, lim, mstat} = 10'h000;
    {cfg, seed, st, prev, n_errors, tests_run} = {8'h00, 32'h33A8, 32'h0, 16'h0, 64'h0};
    {act, pfz, hit} = {16'h0100, 2'b01};
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    settle();
    check("modeDisplay", {8'h00, modeDisplay}, 16'h0002);
    command(16'h0006);
    command(16'h000F);
    command(16'h000F);
    ccw = 1'b1;
    command(16'h000F);
    command(16'h0007);
    command(16'h0006);
    mains = 1'b0;
    command(16'h0007);
    command(16'h000F);
    {mains, cw, ccw} = 3'b110;
    command(16'h000F);
    command(16'h000B);
    sdone = 1'b1;
    settle();
    {sdone, src} = {1'b0, 6'h02};
    command(16'h0006);
    src = CTRL_SRC_STATE_MACHINE;
    flt = 1'b1;
    settle();
    {flt, frd} = 2'b01;
    settle();
    frd = 1'b0;
    command(16'h0006);
    command(16'h0086);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      {warn, pre, lim, mstat} = r[4:0];
      settle();
    end
    // Target band: far, power-fail zero, inside twice the band, out, in
    {act, hit} = {16'h0200, 1'b0};
    settle();
    {pfz, hit} = 2'b11;
    settle();
    {act, pfz} = {16'h0106, 1'b0};
    settle();
    {act, hit} = {16'h010A, 1'b0};
    settle();
    {act, hit} = {16'h0103, 1'b1};
    settle();
    // Motion reference lies far from the actual value
    {cfg, cw, staB, hit} = {CFG_MOTION_LOW, 3'b000};
    command(16'h0006);
    command(16'h000F);
    command(16'h000F);
    staB = 1'b1;
    command(16'h000F);
    plc.sendMode(8'h03);
    repeat (2) @(posedge ref_clk);
    #1 check("modeDisplay", {8'h00, modeDisplay}, 16'h0003);
    cfg = 8'h00;
    plc.sendMode(8'h05);
    repeat (2) @(posedge ref_clk);
    #1 check("modeDisplay", {8'h00, modeDisplay}, 16'h0002);
    summarize();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
endmodule : test_drive_device_state_machine
`default_nettype wire
